/* File: shared/dcap_regs.svh */
`ifndef DCAP_REGS_SVH
`define DCAP_REGS_SVH

// ==========================================================
// Register map (byte addresses, 32-bit words)
`define DCAP_OFS_CTRL 8'h00
`define DCAP_OFS_STATUS 8'h04
`define DCAP_OFS_MR0 8'h08
`define DCAP_OFS_MR1 8'h0C
`define DCAP_OFS_MR2 8'h10
`define DCAP_OFS_MR3 8'h14
`define DCAP_OFS_CMDCNT 8'h18

// ==========================================================
// Control fields and reset value
`define DCAP_CTRL_X8_BIT 0
`define DCAP_CTRL_RST 32'h0000_0000

// ==========================================================
// Status fields
`define DCAP_STS_PWR_LSB 0
`define DCAP_STS_OPEN_LSB 8
`define DCAP_STS_ODT_BIT 16
`define DCAP_STS_TDQS_BIT 17

// ==========================================================
// Mode register fields and reset value
`define DCAP_MR_RST 16'h0000
`define DCAP_MR0_BL_LSB 0
`define DCAP_BL_FIXED8 2'h0
`define DCAP_BL_OTF 2'h1
`define DCAP_BL_FIXED4 2'h2
`define DCAP_MR1_TDQS_BIT 11
`define DCAP_MR1_RTT0_BIT 2
`define DCAP_MR1_RTT1_BIT 6
`define DCAP_MR1_RTT2_BIT 9

// ==========================================================
// Address bit positions
`define DCAP_A_AP_BIT 10
`define DCAP_A_BC_BIT 12

`endif

/* File: shared/dcap_pkg.sv */
package dcap_pkg;

	// ==========================================================
	// Command code {CS#,RAS#,CAS#,WE#}; any code with CS# high is deselect
	typedef enum logic [3:0] {
		DCAP_MRS = 4'h0,
		DCAP_REF = 4'h1,
		DCAP_PRE = 4'h2,
		DCAP_ACT = 4'h3,
		DCAP_WR = 4'h4,
		DCAP_RD = 4'h5,
		DCAP_ZQC = 4'h6,
		DCAP_NOP = 4'h7,
		DCAP_DES = 4'h8
	} dcap_cmd_e;

	typedef enum logic [2:0] {
		DCAP_PW_ACTIVE = 3'h1,
		DCAP_PW_PDN = 3'h2,
		DCAP_PW_SREF = 3'h4
	} dcap_pwr_e;

	// ==========================================================
	// Pins from the controller
	typedef struct packed {
		logic cs_n;
		logic ras_n;
		logic cas_n;
		logic we_n;
		logic [14:0] addr;
		logic [2:0] ba;
		logic cke;
		logic odt;
		logic dm;
		logic wvalid;
		logic [7:0] wdata;
	} dcap_pins_t;

	// Decoded command toward the core
	typedef struct packed {
		logic valid;
		dcap_cmd_e code;
		logic [2:0] bank;
		logic [14:0] addr;
		logic ap;
		logic bc4;
		logic pre_all;
	} dcap_cmd_t;

	// Accepted write beat toward the array
	typedef struct packed {
		logic we;
		logic [7:0] data;
	} dcap_beat_t;

endpackage

/* File: design/dcap_decode.sv */
// Implementation choices: register access over Wishbone and the address map.
`timescale 1ns/1ps
`default_nettype none
`include "dcap_regs.svh"

// How it works
// - Inputs captured on each rising clock edge
// - CS RAS CAS WE form command code
// - CS high masks every command
// - Row on ACT, column and AP on RD/WR
// - PRE: A10 low one bank, high all
// - LOAD MODE writes address as opcode
// - On-the-fly: A12 high BL8, low BC4
// - Bank address picks target bank
// - Bank address picks mode register 0-3
// - CKE synchronous, self-refresh exit included
// - Write beat with DM high is dropped
// - Mode register picks TDQS on x8
// - ODT enables termination unless mode disables or in self refresh
// - Reset is asynchronous, active low
// - TDQS enabled disables write masking
module dcap_decode (
	input wire logic i_clk,
	input wire logic i_reset_n,
	input wire dcap_pkg::dcap_pins_t i_pins,
	input wire logic i_wb_cyc,
	input wire logic i_wb_stb,
	input wire logic i_wb_we,
	input wire logic [7:0] i_wb_adr,
	input wire logic [3:0] i_wb_sel,
	input wire logic [31:0] i_wb_dat,
	output logic o_wb_ack,
	output logic [31:0] o_wb_dat,
	output dcap_pkg::dcap_cmd_t o_cmd,
	output logic [7:0] o_bank_close,
	output logic o_mr_load,
	output logic o_rx_cmd_en,
	output logic o_rx_data_en,
	output logic o_odt_on,
	output logic o_tdqs_en,
	output dcap_pkg::dcap_beat_t o_beat,
	output dcap_pkg::dcap_pwr_e o_pwr
);
	import dcap_pkg::*;

	// ==========================================================
	// Reset release and pin synchronisers
	logic rst_meta;
	logic rst_n;
	dcap_pins_t pin_meta;
	dcap_pins_t pin;

	always_ff @(posedge i_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			rst_meta <= 1'b0;
			rst_n <= 1'b0;
		end else begin
			rst_meta <= 1'b1;
			rst_n <= rst_meta;
		end
	end

	// Capture point is the clock's rising edge only
	always_ff @(posedge i_clk or negedge rst_n) begin
		if (!rst_n) begin
			pin_meta <= '0;
			pin <= '0;
		end else begin
			pin_meta <= i_pins;
			pin <= pin_meta;
		end
	end

	// ==========================================================
	// Helpers
	function automatic dcap_cmd_e decode_cmd(input dcap_pins_t p);
		if (p.cs_n) begin
			decode_cmd = DCAP_DES;
		end else begin
			decode_cmd = dcap_cmd_e'({1'b0, p.ras_n, p.cas_n, p.we_n});
		end
	endfunction

	function automatic logic [7:0] bank_bit(input logic [2:0] b);
		bank_bit = 8'h01 << b;
	endfunction

	// ==========================================================
	// Device state
	logic [15:0] mr [4];
	logic [15:0] next_mr [4];
	logic [7:0] open;
	logic [7:0] next_open;
	logic cke_prev;
	dcap_pwr_e next_pwr;
	dcap_cmd_t next_cmd;
	logic [7:0] next_bank_close;
	logic next_mr_load;
	logic next_odt_on;
	logic next_tdqs_en;
	dcap_beat_t next_beat;
	logic [31:0] cmdcnt;
	logic [31:0] next_cmdcnt;
	logic ctrl_x8;
	dcap_cmd_e cmd;
	logic cmd_live;
	logic rtt_on;

	always_comb begin
		cmd = decode_cmd(pin);
		for (int i = 0; i < 4; i++) begin
			next_mr[i] = mr[i];
		end
		next_open = open;
		next_pwr = o_pwr;
		next_cmd = '0;
		next_cmd.code = DCAP_DES;
		next_bank_close = 8'h00;
		next_mr_load = 1'b0;
		next_cmdcnt = cmdcnt;
		// Commands count only with CKE high now and before, while active
		cmd_live = (o_pwr == DCAP_PW_ACTIVE) && pin.cke && cke_prev;
		case (o_pwr)
			DCAP_PW_ACTIVE: begin
				if (cke_prev && !pin.cke) begin
					if (cmd == DCAP_REF && open == 8'h00) begin
						next_pwr = DCAP_PW_SREF;
					end else begin
						next_pwr = DCAP_PW_PDN;
					end
				end
			end
			DCAP_PW_PDN: begin
				if (pin.cke) begin
					next_pwr = DCAP_PW_ACTIVE;
				end
			end
			DCAP_PW_SREF: begin
				// Exit needs no command, only CKE high sampled at a clock edge
				if (pin.cke) begin
					next_pwr = DCAP_PW_ACTIVE;
				end
			end
			default: begin
				next_pwr = DCAP_PW_ACTIVE;
			end
		endcase
		if (cmd_live && cmd != DCAP_DES && cmd != DCAP_NOP) begin
			next_cmd.valid = 1'b1;
			next_cmd.code = cmd;
			next_cmd.bank = pin.ba;
			next_cmd.addr = pin.addr;
			next_cmdcnt = cmdcnt + 32'h0000_0001;
			case (cmd)
				DCAP_ACT: begin
					next_open = open | bank_bit(pin.ba);
				end
				DCAP_RD, DCAP_WR: begin
					next_cmd.ap = pin.addr[`DCAP_A_AP_BIT];
					if (mr[0][`DCAP_MR0_BL_LSB +: 2] == `DCAP_BL_OTF) begin
						next_cmd.bc4 = !pin.addr[`DCAP_A_BC_BIT];
					end else begin
						next_cmd.bc4 = mr[0][`DCAP_MR0_BL_LSB +: 2] == `DCAP_BL_FIXED4;
					end
					// Auto precharge closes the row at command time, not burst end
					if (pin.addr[`DCAP_A_AP_BIT]) begin
						next_open = open & ~bank_bit(pin.ba);
						next_bank_close = bank_bit(pin.ba);
					end
				end
				DCAP_PRE: begin
					next_cmd.pre_all = pin.addr[`DCAP_A_AP_BIT];
					if (pin.addr[`DCAP_A_AP_BIT]) begin
						next_open = 8'h00;
						next_bank_close = 8'hFF;
					end else begin
						next_open = open & ~bank_bit(pin.ba);
						next_bank_close = bank_bit(pin.ba);
					end
				end
				DCAP_MRS: begin
					// BA2 high names no mode register; opcode dropped
					if (!pin.ba[2]) begin
						next_mr[pin.ba[1:0]] = {1'b0, pin.addr};
						next_mr_load = 1'b1;
					end
				end
				default: begin
				end
			endcase
		end
		rtt_on = mr[1][`DCAP_MR1_RTT0_BIT] | mr[1][`DCAP_MR1_RTT1_BIT] | mr[1][`DCAP_MR1_RTT2_BIT];
		// ODT receiver stays on in power-down, off in self refresh
		next_odt_on = rtt_on && pin.odt && o_pwr != DCAP_PW_SREF && next_pwr != DCAP_PW_SREF;
		next_tdqs_en = ctrl_x8 && mr[1][`DCAP_MR1_TDQS_BIT];
		next_beat.data = pin.wdata;
		next_beat.we = pin.wvalid && o_pwr == DCAP_PW_ACTIVE && (o_tdqs_en || !pin.dm);
	end

	always_ff @(posedge i_clk or negedge rst_n) begin
		if (!rst_n) begin
			for (int i = 0; i < 4; i++) begin
				mr[i] <= `DCAP_MR_RST;
			end
			open <= 8'h00;
			cke_prev <= 1'b0;
			o_pwr <= DCAP_PW_ACTIVE;
			o_cmd <= '0;
			o_bank_close <= 8'h00;
			o_mr_load <= 1'b0;
			o_odt_on <= 1'b0;
			o_tdqs_en <= 1'b0;
			o_beat <= '0;
			o_rx_cmd_en <= 1'b1;
			o_rx_data_en <= 1'b1;
			cmdcnt <= 32'h0000_0000;
		end else begin
			for (int i = 0; i < 4; i++) begin
				mr[i] <= next_mr[i];
			end
			open <= next_open;
			cke_prev <= pin.cke;
			o_pwr <= next_pwr;
			o_cmd <= next_cmd;
			o_bank_close <= next_bank_close;
			o_mr_load <= next_mr_load;
			o_odt_on <= next_odt_on;
			o_tdqs_en <= next_tdqs_en;
			o_beat <= next_beat;
			o_rx_cmd_en <= next_pwr == DCAP_PW_ACTIVE;
			o_rx_data_en <= next_pwr == DCAP_PW_ACTIVE;
			cmdcnt <= next_cmdcnt;
		end
	end

	// ==========================================================
	// Wishbone slave, ack one cycle after the strobe
	logic next_ack;
	logic [31:0] next_dat;
	logic next_x8;
	logic wb_hit;

	always_comb begin
		wb_hit = i_wb_cyc && i_wb_stb && !o_wb_ack;
		next_ack = wb_hit;
		next_x8 = ctrl_x8;
		next_dat = 32'h0000_0000;
		if (wb_hit && i_wb_we) begin
			if (i_wb_adr == `DCAP_OFS_CTRL && i_wb_sel[0]) begin
				next_x8 = i_wb_dat[`DCAP_CTRL_X8_BIT];
			end
		end
		if (wb_hit && !i_wb_we) begin
			if (i_wb_adr == `DCAP_OFS_CTRL) begin
				next_dat[`DCAP_CTRL_X8_BIT] = ctrl_x8;
			end else if (i_wb_adr == `DCAP_OFS_STATUS) begin
				next_dat[`DCAP_STS_PWR_LSB +: 3] = o_pwr;
				next_dat[`DCAP_STS_OPEN_LSB +: 8] = open;
				next_dat[`DCAP_STS_ODT_BIT] = o_odt_on;
				next_dat[`DCAP_STS_TDQS_BIT] = o_tdqs_en;
			end else if (i_wb_adr == `DCAP_OFS_MR0) begin
				next_dat[15:0] = mr[0];
			end else if (i_wb_adr == `DCAP_OFS_MR1) begin
				next_dat[15:0] = mr[1];
			end else if (i_wb_adr == `DCAP_OFS_MR2) begin
				next_dat[15:0] = mr[2];
			end else if (i_wb_adr == `DCAP_OFS_MR3) begin
				next_dat[15:0] = mr[3];
			end else if (i_wb_adr == `DCAP_OFS_CMDCNT) begin
				next_dat = cmdcnt;
			end
		end
	end

	always_ff @(posedge i_clk or negedge rst_n) begin
		if (!rst_n) begin
			o_wb_ack <= 1'b0;
			o_wb_dat <= 32'h0000_0000;
			ctrl_x8 <= 1'(`DCAP_CTRL_RST >> `DCAP_CTRL_X8_BIT);
		end else begin
			o_wb_ack <= next_ack;
			o_wb_dat <= next_dat;
			ctrl_x8 <= next_x8;
		end
	end

	// ==========================================================
	// Checks
	default clocking @(posedge i_clk); endclocking
	default disable iff (!rst_n);

	a_cs_masks_cmd: assert property (
		pin.cs_n |=> !o_cmd.valid)
		else $error("command accepted with chip select high");
	a_cmd_code_follows: assert property (
		o_cmd.valid |-> o_cmd.code == decode_cmd($past(pin)))
		else $error("decoded code differs from captured pins");
	a_pre_all_close: assert property (
		o_cmd.valid && o_cmd.code == DCAP_PRE && o_cmd.pre_all |-> o_bank_close == 8'hFF && open == 8'h00)
		else $error("precharge all left a bank open");
	a_pre_one_bank: assert property (
		o_cmd.valid && o_cmd.code == DCAP_PRE && !o_cmd.pre_all |-> o_bank_close == bank_bit(o_cmd.bank))
		else $error("single precharge closed wrong banks");
	a_mr_load_data: assert property (
		o_mr_load |-> mr[o_cmd.bank[1:0]] == {1'b0, o_cmd.addr} && o_cmd.code == DCAP_MRS)
		else $error("mode register not loaded with opcode");
	a_bc4_otf: assert property (
		o_cmd.valid && (o_cmd.code == DCAP_RD || o_cmd.code == DCAP_WR)
		&& mr[0][1:0] == `DCAP_BL_OTF |-> o_cmd.bc4 == !o_cmd.addr[`DCAP_A_BC_BIT])
		else $error("burst chop does not follow A12");
	a_pdn_no_cmd: assert property (
		o_pwr != DCAP_PW_ACTIVE |=> !o_cmd.valid)
		else $error("command accepted while powered down");
	a_sref_entry: assert property (
		o_pwr == DCAP_PW_ACTIVE && cke_prev && !pin.cke && decode_cmd(pin) == DCAP_REF && open == 8'h00
		|=> o_pwr == DCAP_PW_SREF ##1 !o_rx_data_en)
		else $error("self refresh not entered");
	a_mask_drops: assert property (
		pin.dm && !o_tdqs_en |=> !o_beat.we)
		else $error("masked beat written");
	a_odt_sref_off: assert property (
		o_pwr == DCAP_PW_SREF |-> !o_odt_on)
		else $error("termination on in self refresh");

endmodule

`default_nettype wire

/* File: sim/dcap_ctrl_model.sv */
`timescale 1ns/1ps
`default_nettype none
module dcap_ctrl_model (
	input wire logic i_clk,
	output dcap_pkg::dcap_pins_t o_pins
);
	import dcap_pkg::*;
	initial begin
		o_pins = '0;
		o_pins.cs_n = 1'b1;
		o_pins.cke = 1'b1;
	end
	// Held a full cycle around the capturing edge
	task automatic drive(input logic [3:0] c, input logic [2:0] b, input logic [14:0] a);
		@(posedge i_clk);
		o_pins.cs_n <= c[3];
		{o_pins.ras_n, o_pins.cas_n, o_pins.we_n} <= c[2:0];
		o_pins.ba <= b;
		o_pins.addr <= a;
	endtask
	// Deselected lines flip so stale values never look valid
	task automatic idle();
		drive(4'hF, ~o_pins.ba, ~o_pins.addr);
	endtask
	task automatic beat(input logic m, input logic [7:0] d);
		@(posedge i_clk);
		o_pins.wvalid <= 1'b1;
		o_pins.dm <= m;
		o_pins.wdata <= d;
		@(posedge i_clk);
		o_pins.wvalid <= 1'b0;
		o_pins.wdata <= ~d;
	endtask
	// CKE moves only just after an edge
	task automatic pin_ctl(input logic k, input logic o);
		@(posedge i_clk);
		o_pins.cke <= k;
		o_pins.odt <= o;
	endtask
endmodule
`default_nettype wire

/* File: sim/dcap_decode_test.sv */
`timescale 1ns/1ps
`default_nettype none
module dcap_decode_test;
	import dcap_pkg::*;
	typedef struct packed {dcap_cmd_t c; logic [7:0] cl; logic ml;} dcap_exp_t;
	logic i_clk = 1'b0;
	logic i_reset_n = 1'b0;
	logic cyc = 1'b0, stb = 1'b0, we = 1'b0, ack, mr_load, rx_c, rx_d, odt_on, tdqs_en;
	logic [7:0] adr = '0, bank_close, open_m = '0;
	logic [3:0] sel = '0;
	logic [31:0] wdat = '0, rdat, rng = 32'h3109;
	logic [15:0] mr [4] = '{default: '0};
	logic x8 = 1'b0, awake = 1'b1;
	dcap_pins_t pins;
	dcap_cmd_t cmd_o;
	dcap_beat_t beat_o;
	dcap_pwr_e pwr;
	dcap_exp_t eh;
	dcap_exp_t exp_q [$];
	logic [7:0] beat_q [$];
	int miscompares = 0, cmp_count = 0, ncyc = 0, ncmd = 0;
	always #2 i_clk = ~i_clk;
	dcap_ctrl_model u_dcap_ctrl_model (.i_clk(i_clk), .o_pins(pins));
	dcap_decode u_dcap_decode (.i_clk(i_clk), .i_reset_n(i_reset_n), .i_pins(pins), .i_wb_cyc(cyc),
		.i_wb_stb(stb), .i_wb_we(we), .i_wb_adr(adr), .i_wb_sel(sel), .i_wb_dat(wdat), .o_wb_ack(ack),
		.o_wb_dat(rdat), .o_cmd(cmd_o), .o_bank_close(bank_close), .o_mr_load(mr_load), .o_rx_cmd_en(rx_c),
		.o_rx_data_en(rx_d), .o_odt_on(odt_on), .o_tdqs_en(tdqs_en), .o_beat(beat_o), .o_pwr(pwr));
	// ==========================================================
	// Helpers
	function automatic logic [31:0] rnd();
		rng ^= rng << 13;
		rng ^= rng >> 17;
		rng ^= rng << 5;
		return rng;
	endfunction
	task automatic check(input string n, input logic [63:0] s, input logic [63:0] e);
		cmp_count++;
		if (s !== e) begin
			miscompares++;
			$display("[ERR] %s expected %h seen %h", n, e, s);
		end
	endtask
	task automatic conclude();
		$display("cmp_count=%0d miscompares=%0d", cmp_count, miscompares);
		if (miscompares == 0 && cmp_count > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask
	task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
		int n;
		@(posedge i_clk);
		{cyc, stb, we, adr, wdat, sel} <= {2'b11, w, a, d, 4'hF};
		n = 0;
		// Only the global cycle ceiling ends a hung wait
		do begin
			@(posedge i_clk);
			n++;
		end while (ack !== 1'b1);
		q = rdat;
		check("wb_lat", n, 2);
		{cyc, stb} <= 2'b00;
	endtask
	task automatic settle(input int n);
		repeat (n) @(posedge i_clk);
		@(negedge i_clk);
	endtask
	// Reference decode of one command
	task automatic cmd(input logic [3:0] c, input logic [2:0] b, input logic [14:0] a);
		logic rw;
		dcap_exp_t e;
		rw = (c == DCAP_RD || c == DCAP_WR);
		e.c = '{1'b1, dcap_cmd_e'(c), b, a, rw & a[10], rw & (mr[0][1:0] == 2'h2 ||
			(mr[0][1:0] == 2'h1 && !a[12])), c == DCAP_PRE && a[10]};
		e.cl = e.c.pre_all ? 8'hFF : (e.c.ap || (c == DCAP_PRE)) ? 8'h01 << b : 8'h00;
		e.ml = c == DCAP_MRS && !b[2];
		if (!c[3] && c != DCAP_NOP && awake) begin
			exp_q.push_back(e);
			ncmd++;
			if (e.ml)
				mr[b[1:0]] = {1'b0, a};
			open_m = (open_m | ((c == DCAP_ACT) ? 8'h01 << b : 8'h00)) & ~e.cl;
		end
		u_dcap_ctrl_model.drive(c, b, a);
	endtask
	task automatic bt(input logic m, input logic [7:0] d);
		if (!m || (x8 && mr[1][11]))
			beat_q.push_back(d);
		u_dcap_ctrl_model.beat(m, d);
	endtask
	// ==========================================================
	// Monitors and timeout
	always @(negedge i_clk) begin
		if (cmd_o.valid !== 1'b0) begin
			eh = exp_q.size() ? exp_q.pop_front() : '0;
			check("cmd", cmd_o, eh.c);
			check("bank_close", bank_close, eh.cl);
			check("mr_load", mr_load, eh.ml);
		end
		if (beat_o.we !== 1'b0)
			check("beat", beat_o.data, beat_q.size() ? beat_q.pop_front() : 9'h100);
	end
	always @(posedge i_clk) begin
		ncyc++;
		if (ncyc == 5000) begin
			miscompares++;
			conclude();
		end
	end
	// ==========================================================
	// Main sequence
	initial begin
		logic [31:0] q;
		repeat (2) @(posedge i_clk);
		check("pwr_rst", {pwr, rx_c, rx_d}, {DCAP_PW_ACTIVE, 2'b11});
		i_reset_n <= 1'b1;
		settle(6);
		wb(1'b1, 8'h00, 32'h1, q);
		x8 = 1'b1;
		wb(1'b0, 8'h00, 0, q);
		check("ctrl", q, 32'h1);
		wb(1'b1, 8'h08, 32'hFFFF, q);
		wb(1'b0, 8'h08, 0, q);
		check("mr_ro", q, 0);
		wb(1'b0, 8'h1C, 0, q);
		check("unmapped", q, 0);
		cmd(DCAP_MRS, 3'h0, 15'h0001);
		cmd(DCAP_MRS, 3'h1, 15'h0004);
		cmd(DCAP_MRS, 3'h2, 15'(rnd()));
		cmd(DCAP_MRS, 3'h3, 15'(rnd()));
		cmd(DCAP_MRS, 3'h4, 15'(rnd()));
		for (int i = 0; i < 8; i++) begin
			q = rnd();
			cmd(DCAP_ACT, q[2:0], q[17:3]);
			cmd(q[20] ? DCAP_RD : DCAP_WR, q[2:0], q[31:17]);
		end
		// Fixed burst modes ignore A12
		cmd(DCAP_MRS, 3'h0, 15'h0002);
		cmd(DCAP_RD, 3'h2, 15'h1000);
		cmd(DCAP_MRS, 3'h0, 15'h0000);
		cmd(DCAP_WR, 3'h3, 15'h0000);
		cmd(4'hB, 3'h1, 15'h0);
		cmd(DCAP_PRE, 3'(rnd()), 15'h0000);
		u_dcap_ctrl_model.idle();
		for (int i = 0; i < 4; i++) begin
			wb(1'b0, 8'h08 + 8'(4 * i), 0, q);
			check("mr", q, {16'h0, mr[i]});
		end
		wb(1'b0, 8'h04, 0, q);
		check("open", q[15:8], open_m);
		cmd(DCAP_PRE, 3'h0, 15'h0400);
		for (int i = 0; i < 8; i++)
			cmd(4'(i), 3'h4, 15'h0);
		cmd(DCAP_PRE, 3'h0, 15'h0400);
		u_dcap_ctrl_model.idle();
		bt(1'b0, 8'(rnd()));
		bt(1'b1, 8'(rnd()));
		cmd(DCAP_MRS, 3'h1, 15'h0804);
		u_dcap_ctrl_model.idle();
		settle(5);
		check("tdqs", tdqs_en, 1'b1);
		bt(1'b1, 8'(rnd()));
		u_dcap_ctrl_model.pin_ctl(1'b1, 1'b1);
		settle(5);
		check("odt_on", odt_on, 1'b1);
		cmd(DCAP_MRS, 3'h1, 15'h0800);
		u_dcap_ctrl_model.idle();
		settle(5);
		check("odt_off", odt_on, 1'b0);
		u_dcap_ctrl_model.pin_ctl(1'b0, 1'b0);
		awake = 1'b0;
		settle(5);
		check("pdn", {pwr, rx_c}, {DCAP_PW_PDN, 1'b0});
		cmd(DCAP_ACT, 3'h5, 15'(rnd()));
		u_dcap_ctrl_model.idle();
		u_dcap_ctrl_model.pin_ctl(1'b1, 1'b0);
		settle(6);
		check("pdn_exit", pwr, DCAP_PW_ACTIVE);
		fork
			u_dcap_ctrl_model.drive(DCAP_REF, 3'h0, 15'h0);
			u_dcap_ctrl_model.pin_ctl(1'b0, 1'b0);
		join
		u_dcap_ctrl_model.idle();
		settle(5);
		check("sref", {pwr, rx_d}, {DCAP_PW_SREF, 1'b0});
		u_dcap_ctrl_model.pin_ctl(1'b1, 1'b0);
		awake = 1'b1;
		settle(6);
		check("sref_exit", pwr, DCAP_PW_ACTIVE);
		wb(1'b0, 8'h18, 0, q);
		check("cmdcnt", q, ncmd);
		check("left", {exp_q.size(), beat_q.size()}, 0);
		conclude();
	end
endmodule
`default_nettype wire
